// file: design/spm_pkg.sv
// Constants shared by the stored-program message controller and its helpers.
// Assumes one system clock; command fields arrive already unpacked by network logic.
package spm_pkg;
  localparam int          SEG_COUNT        = 12;
  localparam int          LINE_W           = 4;
  localparam int          BANK_W           = 4;
  localparam int          INSTR_W          = 48;
  localparam logic [3:0]  BUF_BANK         = 4'hC;
  localparam logic [7:0]  MSG_TYPE_MOTION  = 8'h01;
  localparam logic [7:0]  MSG_TYPE_REG     = 8'h02;
  localparam logic [7:0]  OP_SEG_START     = 8'h78;
  localparam logic [7:0]  OP_STOP_KILL     = 8'h98;
  localparam logic [7:0]  OP_UREG_READ     = 8'h9A;
  localparam logic [7:0]  OP_PARAM_WRITE   = 8'h83;
  localparam logic [7:0]  OP_PARAM_READ    = 8'h84;
  localparam logic [7:0]  OP_PREG_WRITE    = 8'h9E;
  localparam logic [7:0]  OP_QUEUE_LOAD    = 8'hD0;
  localparam logic [7:0]  OP_QUEUE_SAVE    = 8'hD1;
  localparam logic [7:0]  OPND_VELOCITY    = 8'h1D;
  localparam logic [7:0]  OPND_STATUS      = 8'h80;
  localparam logic [7:0]  REG_USER_BASE    = 8'h30;
  localparam int          USER_REG_COUNT   = 10;
  localparam logic [7:0]  REG_JOG_SPEED    = 8'h4A;
  localparam logic        STOP_QUICK       = 1'b0;
  localparam logic        STOP_NORMAL      = 1'b1;
  localparam int          STAT_ENABLED_BIT = 0;
  localparam int          STAT_RUN_BIT     = 14;
  localparam int          STAT_WAIT_BIT    = 11;
  localparam logic [15:0] STAT_MOVING_MASK = 16'h0018;
  localparam logic [15:0] RSP_OK           = 16'h0000;
  localparam logic [15:0] RSP_REFUSED      = 16'h0001;
  localparam logic [15:0] RSP_BAD          = 16'h0002;
  localparam logic [15:0] VELOCITY_RST     = 16'h0000;
  localparam logic [15:0] JOG_SPEED_RST    = 16'h0000;
  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_FETCH, ST_COPY_RD, ST_COPY_WR} spm_state_e;
endpackage

// file: design/spm_prog_mem.sv
// Program store: one port, registered read data.
// Assumes the caller never reads and writes in the same cycle.
`timescale 1ns/10ps
module spm_prog_mem
  import spm_pkg::*;
#(
  parameter int WIDTH  = INSTR_W,
  parameter int ADDR_W = BANK_W + LINE_W
)(
  input  wire logic              clk_sys_in,
  input  wire logic              nrst_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              we_in,
  input  wire logic              re_in,
  input  wire logic [WIDTH-1:0]  wdata_in,
  output logic      [WIDTH-1:0]  rdata_out
);
  logic [WIDTH-1:0] mem_r [2**ADDR_W];

  // Array has no reset; a segment is only read below its stored length.
  always_ff @(posedge clk_sys_in)
  begin
    if (we_in)
    begin
      mem_r[addr_in] <= wdata_in;
    end
  end

  // Read data is held until the next read.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rdata_out <= '0;
    end
    else if (re_in)
    begin
      rdata_out <= mem_r[addr_in];
    end
  end
endmodule

// file: design/spm_status.sv
// Builds the drive status word from run state and motion inputs.
// Assumes all inputs are on the system clock.
`timescale 1ns/10ps
module spm_status
  import spm_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  input  wire logic        run_in,
  input  wire logic        wait_in,
  input  wire logic        moving_in,
  input  wire logic        enabled_in,
  output logic      [15:0] status_out
);
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      status_out <= 16'h0000;
    end
    else
    begin
      status_out                   <= moving_in ? STAT_MOVING_MASK : 16'h0000;
      status_out[STAT_ENABLED_BIT] <= enabled_in;
      status_out[STAT_RUN_BIT]     <= run_in;
      status_out[STAT_WAIT_BIT]    <= run_in & wait_in;
    end
  end
endmodule

// file: design/spm_ctrl.sv
// Stored-program message controller: decodes host commands, runs segments, answers.
// Assumes command fields come from same-clock network logic; the instruction
// executor and motion core sit outside and talk over the exec and motion ports.
`timescale 1ns/10ps
module spm_ctrl
  import spm_pkg::*;
(
  input  wire logic               clk_sys_in,
  input  wire logic               nrst_in,
  input  wire logic               cmd_valid_in,
  input  wire logic [7:0]         cmd_type_in,
  input  wire logic [7:0]         cmd_opcode_in,
  input  wire logic [7:0]         cmd_operand_in,
  input  wire logic [31:0]        cmd_data_in,
  output logic                    cmd_ready_out,
  output logic                    rsp_valid_out,
  output logic      [7:0]         rsp_type_out,
  output logic      [7:0]         rsp_opcode_out,
  output logic      [7:0]         rsp_operand_out,
  output logic      [15:0]        rsp_status_out,
  output logic      [31:0]        rsp_value_out,
  input  wire logic               exec_next_in,
  input  wire logic               exec_call_in,
  input  wire logic [3:0]         exec_call_seg_in,
  input  wire logic               exec_wait_in,
  input  wire logic               exec_reg_we_in,
  input  wire logic [3:0]         exec_reg_sel_in,
  input  wire logic [31:0]        exec_reg_data_in,
  output logic                    instr_valid_out,
  output logic      [INSTR_W-1:0] instr_out,
  output logic                    run_out,
  output logic                    stop_pulse_out,
  output logic                    stop_decel_out,
  output logic                    motion_valid_out,
  output logic      [INSTR_W-1:0] motion_cmd_out,
  input  wire logic               move_start_in,
  input  wire logic               moving_in,
  input  wire logic               enabled_in,
  output logic      [15:0]        velocity_out,
  output logic      [15:0]        jog_speed_out,
  output logic      [15:0]        status_word_out
);
  localparam int ADDR_W = BANK_W + LINE_W;

  spm_state_e          state_r;
  logic [3:0]          cur_seg_r;
  logic [LINE_W:0]     pc_r;
  logic [LINE_W:0]     seg_len_r [SEG_COUNT];
  logic [LINE_W:0]     buf_len_r;
  logic [LINE_W:0]     cp_idx_r;
  logic [3:0]          dst_seg_r;
  logic                loading_r;
  logic [15:0]         vel_pend_r;
  logic [31:0]         user_reg_r [USER_REG_COUNT];
  logic [INSTR_W-1:0]  mem_rdata;
  logic [ADDR_W-1:0]   mem_addr;
  logic                mem_we;
  logic                mem_re;
  logic [INSTR_W-1:0]  cmd_word;
  logic                acc;
  logic                is_t1;
  logic                is_t2;
  logic                do_start;
  logic                do_motion;
  logic                do_append;
  logic                do_stop;
  logic                do_buf_open;
  logic                do_buf_save;
  logic                do_vel;
  logic                do_preg;
  logic                do_uread;
  logic                do_pread;
  logic                at_empty;
  logic [15:0]         rsp_code_nxt;

  // Register codes 0x30..0x39 map to user registers; shared by read and write.
  function automatic logic reg_is_user(input logic [7:0] code);
    return (code >= REG_USER_BASE) && (code < REG_USER_BASE + 8'(USER_REG_COUNT));
  endfunction

  // Command decode; a command is taken whenever valid meets ready.
  assign acc      = cmd_valid_in & cmd_ready_out;
  assign is_t1    = cmd_type_in == MSG_TYPE_MOTION;
  assign is_t2    = cmd_type_in == MSG_TYPE_REG;
  assign cmd_word = {cmd_opcode_in, cmd_operand_in, cmd_data_in};
  // A call past the last stored segment ends the run rather than reading
  // beyond the length table, which would leave the end test unknown.
  assign at_empty = (cur_seg_r >= 4'(SEG_COUNT)) | (pc_r == seg_len_r[cur_seg_r]);
  assign do_append = acc & is_t1 & loading_r & (buf_len_r < (LINE_W+1)'(2**LINE_W));
  assign do_start  = acc & is_t1 & ~loading_r & ~run_out & (cmd_opcode_in == OP_SEG_START)
                     & (cmd_operand_in < 8'(SEG_COUNT));
  assign do_motion = acc & is_t1 & ~loading_r & ~run_out & (cmd_opcode_in != OP_SEG_START);
  assign do_stop   = acc & is_t2 & (cmd_opcode_in == OP_STOP_KILL);
  assign do_buf_open = acc & is_t2 & (cmd_opcode_in == OP_QUEUE_LOAD) & ~run_out;
  assign do_buf_save = acc & is_t2 & (cmd_opcode_in == OP_QUEUE_SAVE) & loading_r
                     & (cmd_operand_in < 8'(SEG_COUNT));
  assign do_vel    = acc & is_t2 & (cmd_opcode_in == OP_PARAM_WRITE)
                     & (cmd_operand_in == OPND_VELOCITY);
  assign do_preg   = acc & is_t2 & (cmd_opcode_in == OP_PREG_WRITE)
                     & (reg_is_user(cmd_operand_in) | (cmd_operand_in == REG_JOG_SPEED));
  assign do_uread  = acc & is_t2 & (cmd_opcode_in == OP_UREG_READ)
                     & reg_is_user(cmd_operand_in);
  assign do_pread  = acc & is_t2 & (cmd_opcode_in == OP_PARAM_READ)
                     & (cmd_operand_in == OPND_STATUS);

  // Status code for the answer; anything not carried out is refused or bad.
  always_comb
  begin
    rsp_code_nxt = RSP_BAD;
    if (do_start | do_motion | do_append | do_stop | do_buf_open | do_buf_save | do_vel
        | do_preg
        | do_uread | do_pread)
    begin
      rsp_code_nxt = RSP_OK;
    end
    else if (is_t1 & run_out)
    begin
      rsp_code_nxt = RSP_REFUSED;
    end
  end

  // Memory port: the sequencer and the loader never need it at once, since
  // loading is refused while running and commands stall during a copy.
  always_comb
  begin
    mem_addr = {cur_seg_r, pc_r[LINE_W-1:0]};
    mem_we   = 1'b0;
    mem_re   = 1'b0;
    case (state_r)
      ST_RUN:
      begin
        mem_re = exec_next_in & ~at_empty & ~do_stop & ~exec_call_in;
      end
      ST_COPY_RD:
      begin
        mem_addr = {BUF_BANK, cp_idx_r[LINE_W-1:0]};
        mem_re   = 1'b1;
      end
      ST_COPY_WR:
      begin
        mem_addr = {dst_seg_r, cp_idx_r[LINE_W-1:0]};
        mem_we   = 1'b1;
      end
      default:
      begin
        if (do_append)
        begin
          mem_addr = {BUF_BANK, buf_len_r[LINE_W-1:0]};
          mem_we   = 1'b1;
        end
      end
    endcase
  end

  spm_prog_mem #(
    .WIDTH  (INSTR_W),
    .ADDR_W (ADDR_W)
  ) u_mem (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .addr_in    (mem_addr),
    .we_in      (mem_we),
    .re_in      (mem_re),
    .wdata_in   (state_r == ST_COPY_WR ? mem_rdata : cmd_word),
    .rdata_out  (mem_rdata)
  );

  // Sequencer: runs segments line by line and copies the buffer on save.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_r   <= ST_IDLE;
      cur_seg_r <= 4'h0;
      pc_r      <= '0;
      cp_idx_r  <= '0;
      dst_seg_r <= 4'h0;
      run_out   <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (do_start)
          begin
            state_r   <= ST_RUN;
            cur_seg_r <= cmd_operand_in[3:0];
            pc_r      <= '0;
            run_out   <= 1'b1;
          end
          else if (do_buf_save)
          begin
            state_r   <= ST_COPY_RD;
            dst_seg_r <= cmd_operand_in[3:0];
            cp_idx_r  <= '0;
          end
        end
        ST_RUN:
        begin
          if (do_stop)
          begin
            state_r <= ST_IDLE;
            run_out <= 1'b0;
          end
          else if (exec_call_in)
          begin
            cur_seg_r <= exec_call_seg_in;
            pc_r      <= '0;
          end
          else if (exec_next_in & at_empty)
          begin
            state_r <= ST_IDLE;
            run_out <= 1'b0;
          end
          else if (exec_next_in)
          begin
            state_r <= ST_FETCH;
            pc_r    <= pc_r + 1'b1;
          end
        end
        ST_FETCH:
        begin
          state_r <= do_stop ? ST_IDLE : ST_RUN;
          run_out <= ~do_stop;
        end
        ST_COPY_RD:
        begin
          state_r <= (cp_idx_r == buf_len_r) ? ST_IDLE : ST_COPY_WR;
        end
        ST_COPY_WR:
        begin
          state_r  <= ST_COPY_RD;
          cp_idx_r <= cp_idx_r + 1'b1;
        end
        default:
        begin
          state_r <= ST_IDLE;
          run_out <= 1'b0;
        end
      endcase
    end
  end

  // Commands stall only while the buffer is copied, so save cannot race a load.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cmd_ready_out <= 1'b0;
    end
    else
    begin
      cmd_ready_out <= ~(do_buf_save | (state_r == ST_COPY_WR)
                        | ((state_r == ST_COPY_RD) & (cp_idx_r != buf_len_r)));
    end
  end

  // Queue load opens the buffer; each motion command grows it, up to 16 lines; save closes it.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      loading_r <= 1'b0;
      buf_len_r <= '0;
    end
    else if (do_buf_open)
    begin
      loading_r <= 1'b1;
      buf_len_r <= '0;
    end
    else if (do_buf_save)
    begin
      loading_r <= 1'b0;
    end
    else if (do_append)
    begin
      buf_len_r <= buf_len_r + 1'b1;
    end
  end

  // Segment lengths; a never-saved segment has length zero and ends at once.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      for (int i = 0; i < SEG_COUNT; i++)
      begin
        seg_len_r[i] <= '0;
      end
    end
    else if (do_buf_save)
    begin
      seg_len_r[cmd_operand_in[3:0]] <= buf_len_r;
    end
  end

  // Fetched line goes to the executor one cycle after the memory answers.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      instr_valid_out <= 1'b0;
      instr_out       <= '0;
    end
    else
    begin
      instr_valid_out <= (state_r == ST_FETCH) & ~do_stop;
      if (state_r == ST_FETCH)
      begin
        instr_out <= mem_rdata;
      end
    end
  end

  // Stop and plain motion commands are passed to the motion core as pulses.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      stop_pulse_out   <= 1'b0;
      stop_decel_out   <= STOP_QUICK;
      motion_valid_out <= 1'b0;
      motion_cmd_out   <= '0;
    end
    else
    begin
      stop_pulse_out   <= do_stop;
      motion_valid_out <= do_motion;
      if (do_stop)
      begin
        stop_decel_out <= cmd_operand_in[0] ? STOP_NORMAL : STOP_QUICK;
      end
      if (do_motion)
      begin
        motion_cmd_out <= cmd_word;
      end
    end
  end

  // Velocity is staged so a running move keeps its speed.
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      vel_pend_r   <= VELOCITY_RST;
      velocity_out <= VELOCITY_RST;
    end
    else
    begin
      if (do_vel)
      begin
        vel_pend_r <= cmd_data_in[15:0];
      end
      if (move_start_in)
      begin
        velocity_out <= vel_pend_r;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      jog_speed_out <= JOG_SPEED_RST;
    end
    else if (do_preg & (cmd_operand_in == REG_JOG_SPEED))
    begin
      jog_speed_out <= cmd_data_in[15:0];
    end
  end

  // User registers: a host write wins over a program write in the same cycle.
  for (genvar g = 0; g < USER_REG_COUNT; g++)
  begin : g_ureg
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
      if (!nrst_in)
      begin
        user_reg_r[g] <= 32'h0000_0000;
      end
      else if (do_preg & (cmd_operand_in == REG_USER_BASE + 8'(g)))
      begin
        user_reg_r[g] <= cmd_data_in;
      end
      else if (exec_reg_we_in & (exec_reg_sel_in == 4'(g)))
      begin
        user_reg_r[g] <= exec_reg_data_in;
      end
    end
  end

  spm_status u_status (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .run_in     (run_out),
    .wait_in    (exec_wait_in),
    .moving_in  (moving_in),
    .enabled_in (enabled_in),
    .status_out (status_word_out)
  );

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rsp_valid_out   <= 1'b0;
      rsp_type_out    <= 8'h00;
      rsp_opcode_out  <= 8'h00;
      rsp_operand_out <= 8'h00;
      rsp_status_out  <= RSP_OK;
      rsp_value_out   <= 32'h0000_0000;
    end
    else
    begin
      rsp_valid_out <= acc;
      if (acc)
      begin
        rsp_type_out    <= cmd_type_in;
        rsp_opcode_out  <= cmd_opcode_in;
        rsp_operand_out <= cmd_operand_in;
        rsp_status_out  <= rsp_code_nxt;
        rsp_value_out   <= 32'h0000_0000;
        if (do_uread)
        begin
          rsp_value_out <= user_reg_r[4'(cmd_operand_in - REG_USER_BASE)];
        end
        else if (do_pread)
        begin
          rsp_value_out <= {16'h0000, status_word_out};
        end
      end
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  property p_echo;
    acc |=> rsp_valid_out && rsp_opcode_out == $past(cmd_opcode_in)
            && rsp_operand_out == $past(cmd_operand_in);
  endproperty
  a_echo: assert property (p_echo) else $error("response does not echo command");

  property p_start;
    do_start |=> run_out && cur_seg_r == $past(cmd_operand_in[3:0]) ##1 status_word_out[14];
  endproperty
  a_start: assert property (p_start) else $error("start did not run segment");

  property p_seg_range;
    acc && is_t1 && !loading_r && !run_out && cmd_opcode_in == OP_SEG_START
      && cmd_operand_in >= 8'(SEG_COUNT) |=> !run_out && rsp_status_out == RSP_BAD;
  endproperty
  a_seg_range: assert property (p_seg_range) else $error("bad segment started");

  property p_lockout;
    acc && is_t1 && run_out && !loading_r |=> rsp_status_out == RSP_REFUSED && !motion_valid_out;
  endproperty
  a_lockout: assert property (p_lockout) else $error("motion accepted while running");

  property p_stop;
    do_stop && run_out |=> !run_out && stop_pulse_out
                           && stop_decel_out == $past(cmd_operand_in[0]);
  endproperty
  a_stop: assert property (p_stop) else $error("stop kill did not halt");

  property p_empty_end;
    state_r == ST_RUN && exec_next_in && at_empty && !do_stop && !exec_call_in |=> !run_out;
  endproperty
  a_empty_end: assert property (p_empty_end) else $error("empty line did not end");

  property p_run_bit;
    ##1 status_word_out[STAT_RUN_BIT] == $past(run_out);
  endproperty
  a_run_bit: assert property (p_run_bit) else $error("status bit 14 wrong");

  property p_vel_hold;
    do_vel && !move_start_in |=> $stable(velocity_out);
  endproperty
  a_vel_hold: assert property (p_vel_hold) else $error("velocity changed mid move");

  property p_jog;
    do_preg && cmd_operand_in == REG_JOG_SPEED |=> jog_speed_out == $past(cmd_data_in[15:0]);
  endproperty
  a_jog: assert property (p_jog) else $error("jog speed not updated");

  property p_reg_run;
    (do_uread || do_preg) && run_out |=> rsp_status_out == RSP_OK;
  endproperty
  a_reg_run: assert property (p_reg_run) else $error("register access refused");

  c_start: cover property (do_start ##[1:20] instr_valid_out);
  c_call: cover property (state_r == ST_RUN && exec_call_in);
  c_save: cover property (do_buf_save ##[1:40] state_r == ST_IDLE);
  c_stop: cover property (do_stop && run_out);
endmodule

// file: verification/spm_host_model.sv
// Host model: offers one command message at a time and collects its answer.
// Assumes the controller answers within a few cycles of taking a command.
`timescale 1ns/10ps
module spm_host_model (
  input  wire logic        clk_sys_in,
  input  wire logic        cmd_ready_in,
  input  wire logic        rsp_valid_in,
  input  wire logic [23:0] rsp_echo_in,
  input  wire logic [15:0] rsp_status_in,
  input  wire logic [31:0] rsp_value_in,
  output logic             cmd_valid_out,
  output logic      [55:0] cmd_msg_out
);
  // Idle request lines at time zero.
  initial
  begin
    cmd_valid_out = 1'b0;
    cmd_msg_out = 56'h0;
  end

  // Request held until ready was seen ahead of the taking edge; fields are
  // inverted on release so that a stale message can never pass for a new one.
  // quiet while tool attached
  task automatic send(input logic [55:0] msg, output logic [71:0] rsp);
    int n;
    n = 0;
    @(negedge clk_sys_in);
    cmd_msg_out = msg;
    cmd_valid_out = 1'b1;
    while (cmd_ready_in !== 1'b1 && n < 100)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    @(negedge clk_sys_in);
    cmd_valid_out = 1'b0;
    cmd_msg_out = ~msg;
    n = 0;
    while (rsp_valid_in !== 1'b1 && n < 3)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    // A missing answer reads as unknown so that every check on it fails.
    if (rsp_valid_in === 1'b1)
      rsp = {rsp_echo_in, rsp_status_in, rsp_value_in};
    else
      rsp = 'x;
  endtask
endmodule

// file: verification/tb_top.sv
// Bench for the stored-program controller: the host model sends commands,
// the bench plays executor and motion core and checks every answer.
`timescale 1ns/10ps
module tb_top;
  import spm_pkg::*;
  logic               clk_sys_in = 1'b0;
  logic               nrst_in = 1'b0;
  logic               cmd_valid_in;
  logic [55:0]        msg;
  logic               cmd_ready_out;
  logic               rsp_valid_out;
  logic [7:0]         rsp_type_out;
  logic [7:0]         rsp_opcode_out;
  logic [7:0]         rsp_operand_out;
  logic [15:0]        rsp_status_out;
  logic [31:0]        rsp_value_out;
  logic               exec_next_in = 1'b0;
  logic               exec_wait_in = 1'b0;
  logic               move_start_in = 1'b0;
  logic               moving_in = 1'b0;
  logic               enabled_in = 1'b1;
  logic               exec_call_in = 1'b0;
  logic [3:0]         exec_call_seg_in = 4'h0;
  logic               exec_reg_we_in = 1'b0;
  logic [3:0]         exec_reg_sel_in = 4'h0;
  logic [31:0]        exec_reg_data_in = 32'h0;
  logic               instr_valid_out;
  logic               stop_pulse_out;
  logic               motion_valid_out;
  logic [INSTR_W-1:0] motion_cmd_out;
  logic [15:0]        status_word_out;
  logic [INSTR_W-1:0] instr_out;
  logic               run_out;
  logic               stop_decel_out;
  logic [15:0]        velocity_out;
  logic [15:0]        jog_speed_out;
  logic [71:0]        rsp;
  int                 n_mismatch = 0;
  int                 comparisons = 0;

  // Free-running system clock, 8 ns period.
  always #4 clk_sys_in = ~clk_sys_in;

  spm_host_model host (
    .clk_sys_in    (clk_sys_in),
    .cmd_ready_in  (cmd_ready_out),
    .rsp_valid_in  (rsp_valid_out),
    .rsp_echo_in   ({rsp_type_out, rsp_opcode_out, rsp_operand_out}),
    .rsp_status_in (rsp_status_out),
    .rsp_value_in  (rsp_value_out),
    .cmd_valid_out (cmd_valid_in),
    .cmd_msg_out   (msg)
  );

  // The bench also plays the executor and the motion core on the far ports.
  spm_ctrl dut (
    .clk_sys_in (clk_sys_in), .nrst_in (nrst_in), .cmd_valid_in (cmd_valid_in),
    .cmd_type_in (msg[55:48]), .cmd_opcode_in (msg[47:40]),
    .cmd_operand_in (msg[39:32]), .cmd_data_in (msg[31:0]),
    .cmd_ready_out (cmd_ready_out), .rsp_valid_out (rsp_valid_out),
    .rsp_type_out (rsp_type_out), .rsp_opcode_out (rsp_opcode_out),
    .rsp_operand_out (rsp_operand_out), .rsp_status_out (rsp_status_out),
    .rsp_value_out (rsp_value_out), .exec_next_in (exec_next_in),
    .exec_call_in (exec_call_in), .exec_call_seg_in (exec_call_seg_in),
    .exec_wait_in (exec_wait_in), .exec_reg_we_in (exec_reg_we_in),
    .exec_reg_sel_in (exec_reg_sel_in), .exec_reg_data_in (exec_reg_data_in),
    .instr_valid_out (instr_valid_out), .instr_out (instr_out), .run_out (run_out),
    .stop_pulse_out (stop_pulse_out), .stop_decel_out (stop_decel_out),
    .motion_valid_out (motion_valid_out), .motion_cmd_out (motion_cmd_out),
    .move_start_in (move_start_in), .moving_in (moving_in),
    .enabled_in (enabled_in), .velocity_out (velocity_out),
    .jog_speed_out (jog_speed_out), .status_word_out (status_word_out)
  );

  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  // One command; the echo and the status code are checked on every answer.
  task automatic cmd(input logic [55:0] m, input logic [15:0] st);
    host.send(m, rsp);
    chk("echo", 48'(m[55:32]), 48'(rsp[71:48]));
    chk("status code", 48'(st), 48'(rsp[47:32]));
  endtask

  // The read answer and the port itself must agree with the expected word.
  task automatic stat(input logic [15:0] exp);
    cmd({8'h02, OP_PARAM_READ, OPND_STATUS, 32'h0}, RSP_OK);
    chk("status word", 48'(exp), 48'(rsp[31:0]));
    chk("status port", 48'(exp), 48'(status_word_out));
  endtask

  // Executor asks for the next line; the valid pulse is seen two edges later
  // and the fetched line then holds on instr_out.
  task automatic nxt(input logic v);
    exec_next_in = 1'b1;
    tick(1);
    exec_next_in = 1'b0;
    tick(1);
    chk("line valid", 48'(v), 48'(instr_valid_out));
    tick(2);
  endtask

  // Watchdog well beyond the hundred or so cycles the tests need.
  initial
  begin
    #100us;
    n_mismatch++;
    stop_test;
  end

  initial
  begin
    tick(4);
    chk("ready in reset", 48'h0, 48'(cmd_ready_out));
    tick(1);
    nrst_in = 1'b1;
    stat(16'h0001);
    cmd({8'h02, OP_QUEUE_LOAD, 8'h00, 32'h0}, RSP_OK);
    cmd({8'h01, 8'h20, 8'h05, 32'hA5}, RSP_OK);
    cmd({8'h01, 8'h21, 8'h06, 32'hB6}, RSP_OK);
    cmd({8'h02, OP_QUEUE_SAVE, 8'h0B, 32'h0}, RSP_OK);
    cmd({8'h01, OP_SEG_START, 8'h0C, 32'h0}, RSP_BAD);
    chk("run on bad segment", 48'h0, 48'(run_out));
    cmd({8'h01, OP_SEG_START, 8'h0B, 32'h0}, RSP_OK);
    chk("run", 48'h1, 48'(run_out));
    tick(1);
    stat(16'h4001);
    moving_in = 1'b1;
    tick(2);
    stat(16'h4019);
    moving_in = 1'b0;
    exec_wait_in = 1'b1;
    tick(2);
    stat(16'h4801);
    exec_wait_in = 1'b0;
    cmd({8'h01, 8'h20, 8'h05, 32'h0}, RSP_REFUSED);
    chk("motion while running", 48'h0, 48'(motion_valid_out));
    cmd({8'h02, OP_PREG_WRITE, 8'h39, 32'hFFFFFFFF}, RSP_OK);
    cmd({8'h02, OP_UREG_READ, 8'h39, 32'h0}, RSP_OK);
    chk("user reg 9", 48'hFFFFFFFF, 48'(rsp[31:0]));
    exec_reg_sel_in = 4'h1;
    exec_reg_data_in = 32'h00000C0D;
    exec_reg_we_in = 1'b1;
    tick(1);
    exec_reg_we_in = 1'b0;
    cmd({8'h02, OP_UREG_READ, 8'h31, 32'h0}, RSP_OK);
    chk("user reg 1", 48'hC0D, 48'(rsp[31:0]));
    cmd({8'h02, OP_PREG_WRITE, REG_JOG_SPEED, 32'h55}, RSP_OK);
    tick(1);
    chk("jog speed", 48'h55, 48'(jog_speed_out));
    cmd({8'h02, OP_PARAM_WRITE, OPND_VELOCITY, 32'h1234}, RSP_OK);
    chk("velocity before move", 48'h0, 48'(velocity_out));
    move_start_in = 1'b1;
    tick(1);
    move_start_in = 1'b0;
    tick(1);
    chk("velocity", 48'h1234, 48'(velocity_out));
    nxt(1'b1);
    chk("line 0", {8'h20, 8'h05, 32'hA5}, instr_out);
    nxt(1'b1);
    chk("line 1", {8'h21, 8'h06, 32'hB6}, instr_out);
    exec_call_seg_in = 4'hB;
    exec_call_in = 1'b1;
    tick(1);
    exec_call_in = 1'b0;
    nxt(1'b1);
    chk("line 0 after call", {8'h20, 8'h05, 32'hA5}, instr_out);
    nxt(1'b1);
    nxt(1'b0);
    chk("run after empty line", 48'h0, 48'(run_out));
    cmd({8'h01, OP_SEG_START, 8'h0B, 32'h0}, RSP_OK);
    cmd({8'h02, OP_STOP_KILL, 8'h01, 32'h0}, RSP_OK);
    chk("stop pulse", 48'h1, 48'(stop_pulse_out));
    tick(1);
    chk("run after stop", 48'h0, 48'(run_out));
    chk("normal decel", 48'(STOP_NORMAL), 48'(stop_decel_out));
    cmd({8'h02, OP_STOP_KILL, 8'h00, 32'h0}, RSP_OK);
    tick(1);
    chk("quick decel", 48'(STOP_QUICK), 48'(stop_decel_out));
    cmd({8'h01, 8'h20, 8'h05, 32'hA5}, RSP_OK);
    chk("motion pulse", 48'h1, 48'(motion_valid_out));
    chk("motion cmd", {8'h20, 8'h05, 32'hA5}, motion_cmd_out);
    stat(16'h0001);
    stop_test;
  end
endmodule
